//--- rtl/flash_regs_pkg.sv
// Constants, register map and pin bundle of the flash LED control registers
package flash_regs_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_DC_LIGHT = 8'h01;
    localparam logic [7:0] ADDR_FLASH_CURRENT = 8'h02;
    localparam logic [7:0] ADDR_TIMER_STROBE = 8'h03;
    localparam logic [7:0] ADDR_POWER_THERMAL = 8'h04;

    // Values after reset
    localparam logic [7:0] RST_FLASH_CURRENT = 8'h03;
    localparam logic [7:0] RST_TIMER_STROBE = 8'hC1;
    localparam logic [7:0] RST_POWER_THERMAL = 8'h00;

    // Field positions, flash current register
    localparam int FC_VMODE_BIT = 7;
    localparam int FC_MODE_LSB = 5;
    localparam int FC_OUTER_LSB = 3;
    localparam int FC_CENTRE_LSB = 0;
    // Field positions, timer and strobe register
    localparam int TS_DUR_LSB = 5;
    localparam int TS_FAIL_BIT = 4;
    localparam int TS_RANGE_BIT = 3;
    localparam int TS_TRIG_BIT = 2;
    localparam int TS_START_BIT = 1;
    localparam int TS_BLANK_BIT = 0;
    // Field positions, power and thermal register
    localparam int PT_PG_BIT = 7;
    localparam int PT_TEMP_LSB = 5;
    localparam int PT_INDUCTOR_LIMIT_SELECT_BIT = 4;

    // Operating modes
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_DC_LIGHT = 2'h1;
    localparam logic [1:0] MODE_DC_FLASH = 2'h2;
    localparam logic [1:0] MODE_VOLTAGE = 2'h3;

    // Die temperature code for tripped thermal shutdown
    localparam logic [1:0] TEMP_SHUTDOWN = 2'h3;

    // Timebase: one tick is 0.1 ms
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_NS = 100000;
    localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
    // DC light refresh time-out, 11.2 s, in ticks
    localparam int DCL_TIMEOUT_MS_X10 = 112000;
    localparam logic [16:0] DCL_TIMEOUT_TICKS = 17'(DCL_TIMEOUT_MS_X10);

    // Inductor current limits in mA
    localparam logic [10:0] INDUCTOR_LIMIT_SELECT_LOW_MA = 11'd1250;
    localparam logic [10:0] INDUCTOR_LIMIT_SELECT_HIGH_MA = 11'd1750;
    localparam logic [10:0] INDUCTOR_LIMIT_SELECT_LOW_CUT_MA = 11'd250;
    localparam logic [10:0] INDUCTOR_LIMIT_SELECT_HIGH_CUT_MA = 11'd500;

    // Pin inputs from outside the clock domain
    typedef struct packed {
        logic voltage_mode_pin;
        logic high_current_select_pin;
        logic blanking_pin;
        logic strobe_pin;
        logic led_fault;
        logic power_good;
        logic thermal_trip;
        logic [1:0] temp_band;
    } pin_in_s;

    localparam int PIN_W = $bits(pin_in_s);

    // Register access port from the serial bus engine
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_FLASH = 2'b10
    } strobe_state_e;

endpackage

//--- rtl/pin_sync.sv
// Two-stage synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // One synchroniser per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= async_in[i];
                    sync_q <= meta_q;
                end
            end
            assign sync_out[i] = sync_q;
        end
    endgenerate

endmodule

//--- rtl/flash_led_regs.sv
// Flash LED driver control and status registers with strobe timer
//
// Behaviour
// - Voltage-mode bit reads live pin level
// - Flash current codes use pin-selected table
// - Duration field picks timer length, range bit the long or short table
// - Bit three: range on write, time-out on read
// - Time-out set on expiry, cleared on restart
// - LED failure flag sticky, cleared on read
// - Trigger bit: level or edge, mode 10
// - Writing start one begins flash strobe in mode 01, and in mode 10 unless trigger bit is level and strobe pin low
// - Start bit reads strobe in progress
// - Blanking enable cuts current while pin high
// - Blanking event flag sticky, cleared on read
// - Power-good bit routes signal to GPIO
// - Power-good reads regulation status
// - Temperature band, shutdown code cleared on read
// - Limit bit writable only before first operation
// - Current limit from bit and two pins
// - Mode field encodes four operating modes
// - Mode expires unless refreshed within 11.2 s
// - Mode write through either register updates both
`timescale 1ns/1ns
module flash_led_regs #(
    parameter int TICK_CYCLES = flash_regs_pkg::TICK_CYCLES_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input flash_regs_pkg::reg_req_s req,
    input flash_regs_pkg::pin_in_s pins,
    input wire logic gpio_port_value,
    output logic [7:0] rdata,
    output logic [1:0] mode,
    output logic voltage_mode,
    output logic flash_active,
    output logic [10:0] outer_current_ma,
    output logic [10:0] centre_current_ma,
    output logic blank_cut,
    output logic [10:0] current_limit_ma,
    output logic gpio_out
);

    // Flash current for the outer LEDs, by code and table
    function automatic logic [10:0] outer_ma(input logic hc, input logic [1:0] code);
        logic [10:0] ma;
        ma = 11'd0;
        case ({hc, code})
            3'h0: ma = 11'd250;
            3'h1: ma = 11'd300;
            3'h2: ma = 11'd350;
            3'h3: ma = 11'd400;
            3'h4: ma = 11'd600;
            3'h5: ma = 11'd700;
            3'h6: ma = 11'd800;
            default: ma = 11'd925;
        endcase
        return ma;
    endfunction

    // Flash current for the centre LED, by code and table
    function automatic logic [10:0] centre_ma(input logic hc, input logic [2:0] code);
        logic [10:0] ma;
        ma = 11'd0;
        case ({hc, code})
            4'h0: ma = 11'd275;
            4'h1: ma = 11'd300;
            4'h2: ma = 11'd350;
            4'h3: ma = 11'd450;
            4'h4: ma = 11'd550;
            4'h5: ma = 11'd600;
            4'h6: ma = 11'd700;
            4'h7: ma = 11'd800;
            4'h8: ma = 11'd650;
            4'h9: ma = 11'd700;
            4'hA: ma = 11'd825;
            4'hB: ma = 11'd1050;
            4'hC: ma = 11'd1300;
            4'hD: ma = 11'd1400;
            4'hE: ma = 11'd1500;
            default: ma = 11'd1600;
        endcase
        return ma;
    endfunction

    // Safety timer length in 0.1 ms ticks
    function automatic logic [13:0] timer_ticks(input logic rng, input logic [2:0] code);
        logic [13:0] t;
        t = 14'd0;
        case ({rng, code})
            4'h0: t = 14'd682;
            4'h1: t = 14'd1022;
            4'h2: t = 14'd1363;
            4'h3: t = 14'd1704;
            4'h4: t = 14'd2045;
            4'h5: t = 14'd3408;
            4'h6: t = 14'd5793;
            4'h7: t = 14'd8520;
            4'h8: t = 14'd53;
            4'h9: t = 14'd107;
            4'hA: t = 14'd160;
            4'hB: t = 14'd213;
            4'hC: t = 14'd266;
            4'hD: t = 14'd320;
            4'hE: t = 14'd373;
            default: t = 14'd2077;
        endcase
        return t;
    endfunction

    flash_regs_pkg::pin_in_s pin_s;
    logic [flash_regs_pkg::PIN_W-1:0] pin_sync_vec;
    logic strobe_pin_prev_q;
    logic strobe_rise;

    logic [1:0] mode_q;
    logic [1:0] outer_code_q;
    logic [2:0] centre_code_q;
    logic [2:0] dur_q;
    logic range_q;
    logic trig_edge_q;
    logic blank_en_q;
    logic pg_route_q;
    logic inductor_limit_select_q;
    logic op_started_q;

    logic timeout_q;
    logic fail_flag_q;
    logic blank_flag_q;
    logic thermal_flag_q;

    logic [31:0] tick_cnt_q;
    logic tick;
    logic [16:0] dcl_cnt_q;
    logic [13:0] timer_q;
    flash_regs_pkg::strobe_state_e state_q;

    logic wr_fc;
    logic wr_ts;
    logic wr_pt;
    logic wr_mode;
    logic rd_ts;
    logic rd_pt;
    logic mode_expire;
    logic start_req;
    logic strobe_end;

    pin_sync #(
        .WIDTH(flash_regs_pkg::PIN_W)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(pins),
        .sync_out(pin_sync_vec)
    );
    assign pin_s = flash_regs_pkg::pin_in_s'(pin_sync_vec);

    // Register access decode
    always_comb begin
        wr_fc = 1'b0;
        wr_ts = 1'b0;
        wr_pt = 1'b0;
        wr_mode = 1'b0;
        rd_ts = 1'b0;
        rd_pt = 1'b0;
        if (req.addr == flash_regs_pkg::ADDR_DC_LIGHT) begin
            wr_mode = req.wr_en;
        end else if (req.addr == flash_regs_pkg::ADDR_FLASH_CURRENT) begin
            wr_fc = req.wr_en;
            wr_mode = req.wr_en;
        end else if (req.addr == flash_regs_pkg::ADDR_TIMER_STROBE) begin
            wr_ts = req.wr_en;
            rd_ts = req.rd_en;
        end else if (req.addr == flash_regs_pkg::ADDR_POWER_THERMAL) begin
            wr_pt = req.wr_en;
            rd_pt = req.rd_en;
        end
    end

    // Divider giving one enable pulse per 0.1 ms
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= 32'h0;
        end else if (tick) begin
            tick_cnt_q <= 32'h0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end
    assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

    // DC light refresh watchdog
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dcl_cnt_q <= 17'h0;
        end else if (wr_mode || mode_q == flash_regs_pkg::MODE_SHUTDOWN) begin
            dcl_cnt_q <= 17'h0;
        end else if (tick) begin
            dcl_cnt_q <= dcl_cnt_q + 17'h1;
        end
    end
    assign mode_expire = (dcl_cnt_q >= flash_regs_pkg::DCL_TIMEOUT_TICKS);

    // Mode field shared by both current registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_q <= flash_regs_pkg::RST_FLASH_CURRENT[flash_regs_pkg::FC_MODE_LSB +: 2];
        end else if (wr_mode) begin
            mode_q <= req.wdata[flash_regs_pkg::FC_MODE_LSB +: 2];
        end else if (mode_expire) begin
            mode_q <= flash_regs_pkg::MODE_SHUTDOWN;
        end
    end

    // Flash current codes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            outer_code_q <= flash_regs_pkg::RST_FLASH_CURRENT[flash_regs_pkg::FC_OUTER_LSB +: 2];
            centre_code_q <= flash_regs_pkg::RST_FLASH_CURRENT[flash_regs_pkg::FC_CENTRE_LSB +: 3];
        end else if (wr_fc) begin
            outer_code_q <= req.wdata[flash_regs_pkg::FC_OUTER_LSB +: 2];
            centre_code_q <= req.wdata[flash_regs_pkg::FC_CENTRE_LSB +: 3];
        end
    end

    // Timer and strobe control bits; range is write-only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dur_q <= flash_regs_pkg::RST_TIMER_STROBE[flash_regs_pkg::TS_DUR_LSB +: 3];
            range_q <= flash_regs_pkg::RST_TIMER_STROBE[flash_regs_pkg::TS_RANGE_BIT];
            trig_edge_q <= flash_regs_pkg::RST_TIMER_STROBE[flash_regs_pkg::TS_TRIG_BIT];
            blank_en_q <= flash_regs_pkg::RST_TIMER_STROBE[flash_regs_pkg::TS_BLANK_BIT];
        end else if (wr_ts) begin
            dur_q <= req.wdata[flash_regs_pkg::TS_DUR_LSB +: 3];
            range_q <= req.wdata[flash_regs_pkg::TS_RANGE_BIT];
            trig_edge_q <= req.wdata[flash_regs_pkg::TS_TRIG_BIT];
            blank_en_q <= req.wdata[flash_regs_pkg::TS_BLANK_BIT];
        end
    end

    // Operation-started latch and limit bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            op_started_q <= 1'b0;
            inductor_limit_select_q <= flash_regs_pkg::RST_POWER_THERMAL[flash_regs_pkg::PT_INDUCTOR_LIMIT_SELECT_BIT];
            pg_route_q <= flash_regs_pkg::RST_POWER_THERMAL[flash_regs_pkg::PT_PG_BIT];
        end else begin
            if (mode_q != flash_regs_pkg::MODE_SHUTDOWN) begin
                op_started_q <= 1'b1;
            end
            if (wr_pt) begin
                pg_route_q <= req.wdata[flash_regs_pkg::PT_PG_BIT];
                if (!op_started_q) begin
                    inductor_limit_select_q <= req.wdata[flash_regs_pkg::PT_INDUCTOR_LIMIT_SELECT_BIT];
                end
            end
        end
    end

    // Strobe request sources and end conditions
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strobe_pin_prev_q <= 1'b0;
        end else begin
            strobe_pin_prev_q <= pin_s.strobe_pin;
        end
    end
    assign strobe_rise = pin_s.strobe_pin && !strobe_pin_prev_q;
    always_comb begin
        start_req = wr_ts && req.wdata[flash_regs_pkg::TS_START_BIT]
                    && (mode_q == flash_regs_pkg::MODE_DC_LIGHT || mode_q == flash_regs_pkg::MODE_DC_FLASH);
        if (mode_q == flash_regs_pkg::MODE_DC_FLASH && strobe_rise) begin
            start_req = 1'b1;
        end
        strobe_end = (mode_q == flash_regs_pkg::MODE_SHUTDOWN)
                     || (mode_q == flash_regs_pkg::MODE_DC_FLASH && !trig_edge_q && !pin_s.strobe_pin);
    end

    // Safety timer state machine
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= flash_regs_pkg::ST_IDLE;
            timer_q <= 14'h0;
        end else begin
            case (state_q)
                flash_regs_pkg::ST_IDLE: begin
                    if (start_req && !strobe_end) begin
                        state_q <= flash_regs_pkg::ST_FLASH;
                        // A start written with new timer fields uses those fields
                        timer_q <= timer_ticks(wr_ts ? req.wdata[flash_regs_pkg::TS_RANGE_BIT] : range_q,
                                               wr_ts ? req.wdata[flash_regs_pkg::TS_DUR_LSB +: 3] : dur_q);
                    end
                end
                flash_regs_pkg::ST_FLASH: begin
                    if (strobe_end || (tick && timer_q <= 14'h1)) begin
                        state_q <= flash_regs_pkg::ST_IDLE;
                    end else if (tick) begin
                        timer_q <= timer_q - 14'h1;
                    end
                end
                default: begin
                    state_q <= flash_regs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Time-out flag: set on expiry, cleared by the next start
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timeout_q <= 1'b0;
        end else if (state_q == flash_regs_pkg::ST_FLASH && !strobe_end && tick && timer_q <= 14'h1) begin
            timeout_q <= 1'b1;
        end else if (state_q == flash_regs_pkg::ST_IDLE && start_req && !strobe_end) begin
            timeout_q <= 1'b0;
        end
    end

    // Sticky clear-on-read flags, set wins over the clearing read
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fail_flag_q <= 1'b0;
            blank_flag_q <= 1'b0;
            thermal_flag_q <= 1'b0;
        end else begin
            if (pin_s.led_fault) begin
                fail_flag_q <= 1'b1;
            end else if (rd_ts) begin
                fail_flag_q <= 1'b0;
            end
            if (blank_en_q && pin_s.blanking_pin) begin
                blank_flag_q <= 1'b1;
            end else if (rd_ts) begin
                blank_flag_q <= 1'b0;
            end
            if (pin_s.thermal_trip) begin
                thermal_flag_q <= 1'b1;
            end else if (rd_pt) begin
                thermal_flag_q <= 1'b0;
            end
        end
    end

    // Read data, registered on the read strobe; unmapped reads give zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (req.rd_en) begin
            if (req.addr == flash_regs_pkg::ADDR_FLASH_CURRENT) begin
                rdata <= {pin_s.voltage_mode_pin, mode_q, outer_code_q, centre_code_q};
            end else if (req.addr == flash_regs_pkg::ADDR_TIMER_STROBE) begin
                rdata <= {dur_q, fail_flag_q, timeout_q, trig_edge_q,
                          state_q == flash_regs_pkg::ST_FLASH, blank_flag_q};
            end else if (req.addr == flash_regs_pkg::ADDR_POWER_THERMAL) begin
                rdata <= {pin_s.power_good,
                          thermal_flag_q ? flash_regs_pkg::TEMP_SHUTDOWN : pin_s.temp_band,
                          inductor_limit_select_q, 4'h0};
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    // Analog control outputs
    always_comb begin
        mode = mode_q;
        voltage_mode = pin_s.voltage_mode_pin || mode_q == flash_regs_pkg::MODE_VOLTAGE;
        flash_active = (state_q == flash_regs_pkg::ST_FLASH);
        outer_current_ma = outer_ma(pin_s.high_current_select_pin, outer_code_q);
        centre_current_ma = centre_ma(pin_s.high_current_select_pin, centre_code_q);
        blank_cut = blank_en_q && pin_s.blanking_pin;
        gpio_out = pg_route_q ? gpio_port_value : pin_s.power_good;
        if (pin_s.high_current_select_pin && pin_s.blanking_pin) begin
            current_limit_ma = inductor_limit_select_q ? flash_regs_pkg::INDUCTOR_LIMIT_SELECT_HIGH_CUT_MA : flash_regs_pkg::INDUCTOR_LIMIT_SELECT_LOW_CUT_MA;
        end else begin
            current_limit_ma = inductor_limit_select_q ? flash_regs_pkg::INDUCTOR_LIMIT_SELECT_HIGH_MA : flash_regs_pkg::INDUCTOR_LIMIT_SELECT_LOW_MA;
        end
    end

endmodule

//--- dv/host_model.sv
// Host side model issuing single register accesses
`timescale 1ns/1ns
module host_model (
    input wire logic ref_clk,
    input wire logic [7:0] rdata,
    output flash_regs_pkg::reg_req_s req
);
    initial req = '0;

    // Address then data in one request updates one register
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '0;
    endtask

    // Read is taken at one edge, data sampled once settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        req <= '0;
        #1;
        d = rdata;
    endtask
endmodule

//--- dv/flash_regs_checker.sv
// Port assertions for the flash LED register block
`timescale 1ns/1ns
module flash_regs_checker #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input flash_regs_pkg::reg_req_s req,
    input flash_regs_pkg::pin_in_s pins,
    input wire logic gpio_port_value,
    input wire logic [7:0] rdata,
    input wire logic [1:0] mode,
    input wire logic flash_active,
    input wire logic blank_cut,
    input wire logic [10:0] current_limit_ma,
    input wire logic gpio_out
);
    logic route_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Tracks the written output routing bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            route_q <= 1'b0;
        end else if (req.wr_en && req.addr == 8'h04) begin
            route_q <= req.wdata[7];
        end
    end

    AST_VM_READ: assert property (
        (pins.voltage_mode_pin [*3] ##0 (req.rd_en && req.addr == 8'h02)) |=> rdata[7])
        else $error("voltage mode bit misread");
    AST_MODE_WRITE: assert property (
        req.wr_en && (req.addr == 8'h01 || req.addr == 8'h02) |=> mode == $past(req.wdata[6:5]))
        else $error("mode field not updated");
    AST_START: assert property (
        req.wr_en && req.addr == 8'h03 && req.wdata[1] && !flash_active
        && (mode == 2'h1 || mode == 2'h2) |=> flash_active)
        else $error("strobe did not start");
    AST_ACTIVE_READ: assert property (
        req.rd_en && req.addr == 8'h03 |=> rdata[1] == $past(flash_active))
        else $error("strobe status misread");
    AST_SHUTDOWN: assert property (
        mode == 2'h0 [*2] |-> !flash_active)
        else $error("strobe active in shutdown");
    AST_BLANK_OFF: assert property (
        !pins.blanking_pin [*3] |-> !blank_cut)
        else $error("blanking cut without pin");
    AST_LIMIT_CUT: assert property (
        (pins.high_current_select_pin && pins.blanking_pin) [*4]
        |-> current_limit_ma inside {11'h0FA, 11'h1F4})
        else $error("reduced limit missing");
    AST_LIMIT_NORM: assert property (
        !pins.blanking_pin [*3] |-> current_limit_ma inside {11'h4E2, 11'h6D6})
        else $error("normal limit wrong");
    AST_GPIO_ROUTE: assert property (
        route_q && $past(route_q) && $stable(gpio_port_value) |-> gpio_out == gpio_port_value)
        else $error("port value not routed");
    AST_UNMAPPED: assert property (
        req.rd_en && req.addr == 8'h07 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind flash_led_regs flash_regs_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.ref_clk(ref_clk), .rst(rst),
    .req(req), .pins(pins), .gpio_port_value(gpio_port_value), .rdata(rdata), .mode(mode),
    .flash_active(flash_active), .blank_cut(blank_cut), .current_limit_ma(current_limit_ma),
    .gpio_out(gpio_out));

//--- dv/testbench.sv
// Self-checking bench for the flash LED register block
`timescale 1ns/1ns
module testbench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic gpio_port_value = 1'b0;
    flash_regs_pkg::pin_in_s pins = '0;
    flash_regs_pkg::reg_req_s req;
    logic [7:0] rdata;
    logic [7:0] r;
    logic [1:0] mode;
    logic voltage_mode;
    logic flash_active;
    logic blank_cut;
    logic gpio_out;
    logic [10:0] outer_ma;
    logic [10:0] centre_ma;
    logic [10:0] limit_ma;
    int c;
    int mismatches = 0;
    int checks = 0;

    // Clock of 4 ns
    always #2 ref_clk = ~ref_clk;

    host_model i_host (.ref_clk(ref_clk), .rdata(rdata), .req(req));

    flash_led_regs #(.TICK_CYCLES(4)) i_dut (.ref_clk(ref_clk), .rst(rst), .req(req), .pins(pins),
        .gpio_port_value(gpio_port_value), .rdata(rdata), .mode(mode), .voltage_mode(voltage_mode),
        .flash_active(flash_active), .outer_current_ma(outer_ma), .centre_current_ma(centre_ma),
        .blank_cut(blank_cut), .current_limit_ma(limit_ma), .gpio_out(gpio_out));

    // Compares one value and counts the outcome
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h got %h", n, e, g);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Counts cycles until the strobe ends, bounded
    task automatic wait_idle(output int n);
        n = 0;
        #1;
        while (flash_active === 1'b1 && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask

    task automatic set_strobe(input logic v);
        @(posedge ref_clk);
        pins.strobe_pin <= v;
        cyc(5);
    endtask

    task automatic t_reset;
        chk("outer", 16'h00FA, 16'(outer_ma));
        chk("limit", 16'h04E2, 16'(limit_ma));
        i_host.rd(8'h02, r);
        chk("reg02", 16'h0003, 16'(r));
        i_host.rd(8'h03, r);
        chk("reg03", 16'h00C0, 16'(r));
        i_host.rd(8'h04, r);
        chk("reg04", 16'h0000, 16'(r));
        i_host.rd(8'h07, r);
        chk("unmapped", 16'h0000, 16'(r));
    endtask

    task automatic t_limit;
        i_host.wr(8'h04, 8'h10);
        i_host.rd(8'h04, r);
        chk("inductor_limit_select set", 16'h0010, 16'(r));
        chk("limit hi", 16'h06D6, 16'(limit_ma));
        i_host.wr(8'h01, 8'h20);
        i_host.rd(8'h02, r);
        chk("mode copy", 16'h0023, 16'(r));
        chk("mode out", 16'h0001, 16'(mode));
        i_host.wr(8'h04, 8'h00);
        i_host.rd(8'h04, r);
        chk("inductor_limit_select held", 16'h0010, 16'(r));
        @(posedge ref_clk);
        pins.high_current_select_pin <= 1'b1;
        pins.blanking_pin <= 1'b1;
        cyc(4);
        chk("limit cut", 16'h01F4, 16'(limit_ma));
        chk("cut", 16'h0001, 16'(blank_cut));
        @(posedge ref_clk);
        pins.blanking_pin <= 1'b0;
        cyc(3);
        i_host.rd(8'h03, r);
        chk("blank flag", 16'h0001, 16'(r[0]));
        i_host.rd(8'h03, r);
        chk("blank clear", 16'h0000, 16'(r[0]));
    endtask

    task automatic t_current;
        i_host.wr(8'h02, 8'h3F);
        cyc(1);
        chk("outer hc", 16'h039D, 16'(outer_ma));
        chk("centre hc", 16'h0640, 16'(centre_ma));
        @(posedge ref_clk);
        pins.high_current_select_pin <= 1'b0;
        pins.voltage_mode_pin <= 1'b1;
        i_host.wr(8'h02, 8'h20);
        cyc(3);
        chk("outer lo", 16'h00FA, 16'(outer_ma));
        chk("centre lo", 16'h0113, 16'(centre_ma));
        i_host.rd(8'h02, r);
        chk("vm read", 16'h00A0, 16'(r));
        chk("vm out", 16'h0001, 16'(voltage_mode));
        @(posedge ref_clk);
        pins.voltage_mode_pin <= 1'b0;
        i_host.wr(8'h01, 8'h60);
        cyc(3);
        chk("vs mode", 16'h0003, 16'(mode));
        chk("vs out", 16'h0001, 16'(voltage_mode));
        i_host.wr(8'h01, 8'h20);
        cyc(1);
        chk("vs off", 16'h0000, 16'(voltage_mode));
    endtask

    task automatic t_strobe;
        i_host.wr(8'h03, 8'h0A);
        wait_idle(c);
        chk("strobe len", 16'h0001, 16'(c >= 206 && c <= 213));
        i_host.rd(8'h03, r);
        chk("timeout", 16'h0008, 16'(r));
        i_host.wr(8'h03, 8'h0A);
        i_host.rd(8'h03, r);
        chk("active", 16'h0002, 16'(r));
        i_host.wr(8'h03, 8'h08);
        cyc(1);
        chk("no stop", 16'h0001, 16'(flash_active));
        i_host.wr(8'h02, 8'h00);
        cyc(2);
        chk("shutdown", 16'h0000, 16'(flash_active));
    endtask

    task automatic t_trigger;
        i_host.wr(8'h02, 8'h40);
        i_host.wr(8'h03, 8'h0C);
        set_strobe(1'b1);
        chk("edge on", 16'h0001, 16'(flash_active));
        set_strobe(1'b0);
        chk("edge hold", 16'h0001, 16'(flash_active));
        wait_idle(c);
        i_host.wr(8'h03, 8'h08);
        set_strobe(1'b1);
        chk("level on", 16'h0001, 16'(flash_active));
        set_strobe(1'b0);
        chk("level off", 16'h0000, 16'(flash_active));
    endtask

    task automatic t_status;
        @(posedge ref_clk);
        pins <= 9'h01D;
        cyc(4);
        @(posedge ref_clk);
        pins <= 9'h009;
        cyc(3);
        i_host.rd(8'h03, r);
        chk("fail", 16'h0001, 16'(r[4]));
        i_host.rd(8'h03, r);
        chk("fail clear", 16'h0000, 16'(r[4]));
        i_host.rd(8'h04, r);
        chk("hot trip", 16'h00F0, 16'(r));
        i_host.rd(8'h04, r);
        chk("hot clear", 16'h00B0, 16'(r));
        chk("gpio pg", 16'h0001, 16'(gpio_out));
        i_host.wr(8'h04, 8'h80);
        cyc(2);
        chk("gpio port", 16'h0000, 16'(gpio_out));
        @(posedge ref_clk);
        gpio_port_value <= 1'b1;
        cyc(2);
        chk("gpio port1", 16'h0001, 16'(gpio_out));
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(1);
        t_reset();
        t_limit();
        t_current();
        t_strobe();
        t_trigger();
        t_status();
        results();
    end

    // Cuts a hung run short
    initial begin
        #20000;
        mismatches++;
        results();
    end
endmodule
